// File: dv/mbs_master_model.sv
// Stand-in for the Modbus master: one decoded request at a time.
// Assumes the slave's request handshake on one shared clock.
`timescale 1ns/100ps

module mbs_master_model (
   input wire logic clk, // System clock
   input wire logic req_ready, // Slave takes request
   input wire logic rsp_valid, // Response pulse
   input wire logic rsp_exception, // Exception flag
   input wire logic [15:0] rsp_data, // Response data
   output logic req_valid, // Request present
   output logic [7:0] req_unit_id, // Addressed unit
   output logic [7:0] req_function, // Function code
   output logic [15:0] req_address, // Data address
   output logic [15:0] req_value // Write value
);
   // Idle bus at time zero
   initial
   begin
      req_valid = 1'b0;
      req_unit_id = 8'h00;
      req_function = 8'h00;
      req_address = 16'h0000;
      req_value = 16'h0000;
   end

   // One transfer; idle cycles first model a slow master. Fields are
   // inverted on release so stale values can never pass as a request.
   task automatic xfer(input logic [7:0] unit, input logic [7:0] fn,
      input logic [15:0] addr, input logic [15:0] val, input int idle,
      output logic got, output logic exc, output logic [15:0] data);
      logic r;
      got = 1'b0;
      exc = 1'b0;
      data = 16'h0000;
      r = 1'b0;
      repeat (idle) @(posedge clk);
      @(posedge clk);
      req_valid <= 1'b1;
      req_unit_id <= unit;
      req_function <= fn;
      req_address <= addr;
      req_value <= val;
      repeat (8)
         if (!r)
         begin
            @(negedge clk);
            r = req_ready;
            @(posedge clk);
         end
      req_valid <= 1'b0;
      req_unit_id <= ~unit;
      req_function <= ~fn;
      req_address <= ~addr;
      req_value <= ~val;
      // Response pulse lands within two cycles of the take
      repeat (4)
      begin
         @(negedge clk);
         if (rsp_valid && !got)
         begin
            got = 1'b1;
            exc = rsp_exception;
            data = rsp_data;
         end
      end
   endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench of the Modbus slave, scenarios run in order.
// Assumes src/ holds the header, package and design modules.
`timescale 1ns/100ps
`include "mbs_cfg.svh"

module testbench;
   logic clk, reset_n, clk_en, cfg_load, cfg_dhcp_enable;
   logic dhcp_lease_valid, open_limit_indicator, close_limit_indicator;
   logic error_relay_status, req_valid, req_ready, rsp_valid;
   logic rsp_exception, open_command, rx_timeout, dhcp_request;
   logic [7:0] cfg_node_id, req_unit_id, req_function, rsp_function;
   logic [2:0] cfg_baud_sel;
   logic [4:0] cfg_timeout_sel;
   logic [31:0] cfg_static_ip, cfg_static_gw, cfg_subnet_mask;
   logic [31:0] dhcp_lease_ip, active_ip_address, gateway_address;
   logic [31:0] subnet_mask;
   logic [15:0] cfg_tcp_port, lot_number, req_address, req_value;
   logic [15:0] rsp_data, bit_period_cycles, tcp_listen_port;
   logic [47:0] mac_address;
   logic [7:0] node;
   int n_mismatch, n_tests, slow;
   int rate [6] = '{`MBS_BAUD_4800, `MBS_BAUD_9600, `MBS_BAUD_19200,
      `MBS_BAUD_38400, `MBS_BAUD_57600, `MBS_BAUD_115200};

   // Short second keeps timeout runs brief
   mbs_slave #(.CYCLES_PER_SEC(10), .HOLD_DEPTH(8)) mbs_slave_i (.*);
   mbs_master_model mbs_master_model_i (.*);

   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Pulse cfg_load; network fields keep whatever the caller set
   task automatic load(input logic [7:0] nd, input logic [2:0] bd,
      input logic [4:0] ts);
      @(posedge clk);
      cfg_node_id <= nd;
      cfg_baud_sel <= bd;
      cfg_timeout_sel <= ts;
      cfg_load <= 1'b1;
      @(posedge clk);
      cfg_load <= 1'b0;
      @(negedge clk);
   endtask

   // One request; answer presence, flag, data and echo are judged
   task automatic xact(input logic [7:0] unit, input logic [7:0] fn,
      input logic [15:0] addr, input logic [15:0] val, input logic eg,
      input logic ee, input logic [15:0] ed);
      logic got, exc;
      logic [15:0] data;
      mbs_master_model_i.xfer(unit, fn, addr, val, slow, got, exc, data);
      check(48'(got), 48'(eg));
      if (eg)
      begin
         check(48'(exc), 48'(ee));
         check(48'(data), 48'(ed));
         check(48'(rsp_function), 48'(fn));
      end
   endtask

   task automatic t_reset();
      check(48'(tcp_listen_port), 48'(`MBS_RST_TCP_PORT));
      check(48'(bit_period_cycles), 48'(`MBS_CLK_HZ / 9600));
      check(48'({open_command, rx_timeout, dhcp_request}), 48'h0);
      check(48'(active_ip_address), 48'h0);
   endtask

   task automatic t_node();
      load(8'hff, 3'h1, `MBS_TIMEOUT_NONE);
      xact(8'h01, `MBS_FN_READ_INPUTS, 16'h0, 16'h0, 0, 0, 0);
      xact(8'hff, `MBS_FN_READ_INPUTS, 16'h0, 16'h0, 1, 0, 16'h0);
      load(8'h00, 3'h1, `MBS_TIMEOUT_NONE);
      xact(8'hff, `MBS_FN_READ_INPUTS, 16'h0, 16'h0, 1, 0, 16'h0);
      node = 8'h2a;
      load(node, 3'h1, `MBS_TIMEOUT_NONE);
   endtask

   task automatic t_baud();
      for (int i = 0; i < 6; i++)
      begin
         load(node, 3'(i), `MBS_TIMEOUT_NONE);
         check(48'(bit_period_cycles), 48'(`MBS_CLK_HZ / rate[i]));
      end
      load(node, 3'h6, `MBS_TIMEOUT_NONE);
      check(48'(bit_period_cycles), 48'(`MBS_CLK_HZ / rate[5]));
      // Frozen clock enable must swallow the load
      @(posedge clk);
      clk_en <= 1'b0;
      load(node, 3'h0, `MBS_TIMEOUT_NONE);
      @(posedge clk);
      clk_en <= 1'b1;
      @(negedge clk);
      check(48'(bit_period_cycles), 48'(`MBS_CLK_HZ / rate[5]));
   endtask

   task automatic t_coil();
      xact(node, `MBS_FN_WRITE_COIL, 16'h0, `MBS_COIL_ON, 1, 0,
         `MBS_COIL_ON);
      check(48'(open_command), 48'h1);
      xact(node, `MBS_FN_READ_COILS, 16'h0, 16'h0, 1, 0, 16'h1);
      xact(node, `MBS_FN_WRITE_COIL, 16'h0, 16'h1234, 1, 1,
         `MBS_EXC_VALUE);
      check(48'(open_command), 48'h1);
      xact(node, `MBS_FN_WRITE_COIL, 16'h0, `MBS_COIL_OFF, 1, 0,
         `MBS_COIL_OFF);
      check(48'(open_command), 48'h0);
      xact(node, `MBS_FN_READ_COILS, 16'h1, 16'h0, 1, 1,
         `MBS_EXC_ADDRESS);
      xact(node, 8'h10, 16'h0, 16'h0, 1, 1, `MBS_EXC_FUNCTION);
   endtask

   task automatic t_inputs();
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         open_limit_indicator <= 1'(i);
         close_limit_indicator <= 1'(1 - i);
         error_relay_status <= 1'(i);
         xact(node, `MBS_FN_READ_INPUTS, 16'h0, 0, 1, 0, 16'(i));
         xact(node, `MBS_FN_READ_INPUTS, 16'h1, 0, 1, 0, 16'(1 - i));
         xact(node, `MBS_FN_READ_INPUTS, 16'h2, 0, 1, 0, 16'(i));
      end
      xact(node, `MBS_FN_READ_INPUTS, 16'h270f, 0, 1, 1,
         `MBS_EXC_ADDRESS);
   endtask

   task automatic t_regs();
      slow = 3;
      xact(node, `MBS_FN_WRITE_HOLDING, 16'h7, 16'h5a3c, 1, 0,
         16'h5a3c);
      xact(node, `MBS_FN_WRITE_HOLDING, 16'h0, 16'hbeef, 1, 0,
         16'hbeef);
      slow = 0;
      // The slave must refuse the cycle after a holding read is taken
      fork
         xact(node, `MBS_FN_READ_HOLDING, 16'h7, 0, 1, 0, 16'h5a3c);
         begin
            do
               @(posedge clk);
            while (!(req_valid && req_ready));
            @(negedge clk);
            check(48'(req_ready), 48'h0);
         end
      join
      xact(node, `MBS_FN_READ_HOLDING, 16'h8, 0, 1, 1,
         `MBS_EXC_ADDRESS);
      xact(node, `MBS_FN_READ_IREGS, 16'h0, 0, 1, 0,
         mac_address[47:32]);
      xact(node, `MBS_FN_READ_IREGS, 16'h1, 0, 1, 0,
         mac_address[31:16]);
      xact(node, `MBS_FN_READ_IREGS, 16'h2, 0, 1, 0,
         mac_address[15:0]);
      xact(node, `MBS_FN_READ_IREGS, 16'h3, 0, 1, 0, lot_number);
      xact(node, `MBS_FN_READ_IREGS, 16'h4, 0, 1, 1,
         `MBS_EXC_ADDRESS);
   endtask

   task automatic t_network();
      @(posedge clk);
      cfg_static_ip <= 32'hc0a80a05;
      cfg_static_gw <= 32'hc0a80a01;
      cfg_subnet_mask <= 32'hffffff00;
      cfg_tcp_port <= 16'h1f90;
      dhcp_lease_valid <= 1'b1;
      load(node, 3'h1, `MBS_TIMEOUT_NONE);
      check(48'(active_ip_address), 48'hc0a80a05);
      check(48'(gateway_address), 48'hc0a80a01);
      check(48'(subnet_mask), 48'hffffff00);
      check(48'(tcp_listen_port), 48'h1f90);
      check(48'(dhcp_request), 48'h0);
      @(posedge clk);
      cfg_dhcp_enable <= 1'b1;
      dhcp_lease_valid <= 1'b0;
      load(node, 3'h1, `MBS_TIMEOUT_NONE);
      check(48'(active_ip_address), 48'hc0a80a05);
      check(48'(dhcp_request), 48'h1);
      @(posedge clk);
      dhcp_lease_valid <= 1'b1;
      @(negedge clk);
      check(48'(active_ip_address), 48'(dhcp_lease_ip));
   endtask

   // Two seconds of ten cycles each: twenty idle cycles trip it
   task automatic t_timeout();
      load(node, 3'h1, 5'h02);
      xact(node, `MBS_FN_READ_COILS, 16'h0, 0, 1, 0, 16'h0);
      repeat (12) @(negedge clk);
      check(48'(rx_timeout), 48'h0);
      repeat (12) @(negedge clk);
      check(48'(rx_timeout), 48'h1);
      xact(node, `MBS_FN_READ_COILS, 16'h0, 0, 1, 0, 16'h0);
      check(48'(rx_timeout), 48'h0);
      load(node, 3'h1, `MBS_TIMEOUT_NONE);
      repeat (40) @(negedge clk);
      check(48'(rx_timeout), 48'h0);
      // Out-of-range selection is refused, one second stays in force
      load(node, 3'h1, 5'h01);
      load(node, 3'h1, 5'h15);
      repeat (20) @(negedge clk);
      check(48'(rx_timeout), 48'h1);
   endtask

   // Inputs at time zero, reset for two cycles, then the scenarios
   initial
   begin
      {reset_n, cfg_load, cfg_dhcp_enable, dhcp_lease_valid} = 4'h0;
      {open_limit_indicator, close_limit_indicator} = 2'h0;
      error_relay_status = 1'b0;
      clk_en = 1'b1;
      {cfg_node_id, cfg_baud_sel, cfg_timeout_sel} = 16'h0;
      {cfg_static_ip, cfg_static_gw, cfg_subnet_mask} = 96'h0;
      cfg_tcp_port = 16'h0;
      dhcp_lease_ip = 32'h0a000063;
      mac_address = 48'h02a1b2c3d4e5;
      lot_number = 16'h4d21;
      node = 8'h01;
      n_mismatch = 0;
      n_tests = 0;
      slow = 0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      t_reset();
      t_node();
      t_baud();
      t_coil();
      t_inputs();
      t_regs();
      t_network();
      t_timeout();
      finish_test();
   end

   // Watchdog well past the roughly three hundred cycles needed
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end
endmodule

// File: src/mbs_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// Modbus slave block. Assumes inclusion by bare name from src/.
`ifndef MBS_CFG_SVH
`define MBS_CFG_SVH

// System clock and derived time counts
`define MBS_CLK_HZ 20000000
`define MBS_CLK_PERIOD_NS 50
`define MBS_SECOND_NS 1000000000
`define MBS_CYCLES_PER_SEC (`MBS_SECOND_NS / `MBS_CLK_PERIOD_NS)

// Selectable serial rates, index 0..5
`define MBS_BAUD_4800 4800
`define MBS_BAUD_9600 9600
`define MBS_BAUD_19200 19200
`define MBS_BAUD_38400 38400
`define MBS_BAUD_57600 57600
`define MBS_BAUD_115200 115200
`define MBS_BAUD_SEL_MAX 3'h5

// Receive idle timeout selection: 0 is NONE, 1..20 seconds
`define MBS_TIMEOUT_NONE 5'h00
`define MBS_TIMEOUT_MAX 5'h14

// Data address span of every table
`define MBS_TABLE_LAST 16'h270e

// Output coils
`define MBS_COIL_OPEN_CLOSE 16'h0000
// Input coils
`define MBS_IN_OPEN_LIMIT 16'h0000
`define MBS_IN_CLOSE_LIMIT 16'h0001
`define MBS_IN_ERROR_RELAY 16'h0002
// Input registers: hardware address words, then lot number
`define MBS_IREG_MAC_HI 16'h0000
`define MBS_IREG_MAC_MID 16'h0001
`define MBS_IREG_MAC_LO 16'h0002
`define MBS_IREG_LOT 16'h0003

// Function codes
`define MBS_FN_READ_COILS 8'h01
`define MBS_FN_READ_INPUTS 8'h02
`define MBS_FN_READ_HOLDING 8'h03
`define MBS_FN_READ_IREGS 8'h04
`define MBS_FN_WRITE_COIL 8'h05
`define MBS_FN_WRITE_HOLDING 8'h06

// Single coil write values
`define MBS_COIL_ON 16'hff00
`define MBS_COIL_OFF 16'h0000

// Exception codes
`define MBS_EXC_FUNCTION 16'h0001
`define MBS_EXC_ADDRESS 16'h0002
`define MBS_EXC_VALUE 16'h0003

// Reset values
`define MBS_RST_NODE_ID 8'h01
`define MBS_RST_BAUD_SEL 3'h1
`define MBS_RST_TCP_PORT 16'h01f6

`endif

// File: src/mbs_mem.sv
// Holding register store of the Modbus slave: one write port, one read
// port, read data from a register one cycle after the read strobe.
// Assumes a single clock shared with the slave and its clock enable.
`timescale 1ns/100ps

module mbs_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic wr_en, // Write strobe
   input wire logic [AW-1:0] wr_addr, // Write word index
   input wire logic [WIDTH-1:0] wr_data, // Write data
   input wire logic rd_en, // Read strobe
   input wire logic [AW-1:0] rd_addr, // Read word index
   output logic [WIDTH-1:0] rd_data // Registered read data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [WIDTH-1:0] rd_data;
   } mbs_mem_type;

   mbs_mem_type s;
   mbs_mem_type next_s;

   // Write wins over read to the same word only in the stored copy
   always_comb
   begin
      next_s = s;
      if (wr_en)
         next_s.words[wr_addr] = wr_data;
      if (rd_en)
         next_s.rd_data = s.words[rd_addr];
   end

   // Whole store clears at reset so reads are defined
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         s <= '0;
      else if (clk_en)
         s <= next_s;
   end

   assign rd_data = s.rd_data;

endmodule

// File: src/mbs_pkg.sv
// Types of the Modbus slave block.
// Assumes mbs_cfg.svh is reachable by bare name.
`include "mbs_cfg.svh"

package mbs_pkg;

   typedef enum logic [1:0] {
      MBS_IDLE,
      MBS_HOLD_WAIT
   } mbs_state_type;

   typedef struct packed {
      mbs_state_type state;
      logic [7:0] node_id;
      logic [2:0] baud_sel;
      logic [4:0] timeout_sel;
      logic [31:0] static_ip;
      logic [31:0] static_gw;
      logic [31:0] subnet_mask;
      logic [15:0] tcp_port;
      logic dhcp_en;
      logic open_cmd;
      logic [31:0] presc;
      logic [4:0] secs;
      logic rx_timeout;
      logic rsp_valid;
      logic rsp_exc;
      logic [7:0] rsp_func;
      logic [15:0] rsp_data;
   } mbs_slave_type;

endpackage

// File: src/mbs_slave.sv
// Modbus slave command interpreter and settings holder of the actuator
// controller. Assumes framing (serial or TCP) is done outside: one
// decoded single-item request arrives per handshake, on the same clock.
`timescale 1ns/100ps
`include "mbs_cfg.svh"

module mbs_slave #(
   parameter int CYCLES_PER_SEC = `MBS_CYCLES_PER_SEC,
   parameter int HOLD_DEPTH = 8
) (
   input wire logic clk, // System clock, 20 MHz
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic cfg_load, // Pulse: take the cfg_ values below
   input wire logic [7:0] cfg_node_id, // Node id, 0 is ignored
   input wire logic [2:0] cfg_baud_sel, // Rate index 0..5
   input wire logic [4:0] cfg_timeout_sel, // 0 none, 1..20 seconds
   input wire logic [31:0] cfg_static_ip, // Static network address
   input wire logic [31:0] cfg_static_gw, // Static gateway address
   input wire logic [31:0] cfg_subnet_mask, // Subnet mask
   input wire logic [15:0] cfg_tcp_port, // TCP listen port
   input wire logic cfg_dhcp_enable, // Automatic address option
   input wire logic dhcp_lease_valid, // Lease held by the stack
   input wire logic [31:0] dhcp_lease_ip, // Leased address
   input wire logic [47:0] mac_address, // Fixed hardware address
   input wire logic [15:0] lot_number, // Fixed lot number
   input wire logic open_limit_indicator, // Fully-open indicator on
   input wire logic close_limit_indicator, // Fully-closed indicator on
   input wire logic error_relay_status, // Error relay on
   input wire logic req_valid, // Request present
   input wire logic [7:0] req_unit_id, // Addressed unit
   input wire logic [7:0] req_function, // Function code
   input wire logic [15:0] req_address, // Data address
   input wire logic [15:0] req_value, // Write value
   output logic req_ready, // Request accepted when high
   output logic rsp_valid, // Response present, one cycle
   output logic rsp_exception, // Response is an exception
   output logic [7:0] rsp_function, // Echoed function code
   output logic [15:0] rsp_data, // Read data, echo or exception
   output logic open_command, // 1 open, 0 close
   output logic rx_timeout, // Idle timeout tripped
   output logic [15:0] bit_period_cycles, // Clocks per serial bit
   output logic [31:0] active_ip_address, // Address in use
   output logic [31:0] gateway_address, // Static gateway in use
   output logic [31:0] subnet_mask, // Subnet mask in use
   output logic [15:0] tcp_listen_port, // Port to listen on
   output logic dhcp_request // Ask the stack for a lease
);

   localparam int AW = $clog2(HOLD_DEPTH);

   mbs_pkg::mbs_slave_type s;
   mbs_pkg::mbs_slave_type next_s;
   logic take;
   logic for_us;
   logic mem_wr;
   logic mem_rd;
   logic [15:0] mem_rd_data;

   // Clocks per bit for a rate index; out-of-range picks the slowest
   function automatic logic [15:0] baud_div(input logic [2:0] sel);
      int rate;
      case (sel)
         3'h0: rate = `MBS_BAUD_4800;
         3'h1: rate = `MBS_BAUD_9600;
         3'h2: rate = `MBS_BAUD_19200;
         3'h3: rate = `MBS_BAUD_38400;
         3'h4: rate = `MBS_BAUD_57600;
         3'h5: rate = `MBS_BAUD_115200;
         default: rate = `MBS_BAUD_4800;
      endcase
      return 16'(`MBS_CLK_HZ / rate);
   endfunction

   // Handshake: one request at a time, none while a read is pending
   assign req_ready = (s.state == mbs_pkg::MBS_IDLE);
   assign take = req_valid && req_ready && clk_en;
   assign for_us = (req_unit_id == s.node_id);
   assign mem_wr = take && for_us
      && req_function == `MBS_FN_WRITE_HOLDING
      && req_address < 16'(HOLD_DEPTH);
   assign mem_rd = take && for_us
      && req_function == `MBS_FN_READ_HOLDING
      && req_address < 16'(HOLD_DEPTH);

   mbs_mem #(
      .WIDTH(16),
      .DEPTH(HOLD_DEPTH),
      .AW(AW)
   ) u_hold (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .wr_en(mem_wr),
      .wr_addr(req_address[AW-1:0]),
      .wr_data(req_value),
      .rd_en(mem_rd),
      .rd_addr(req_address[AW-1:0]),
      .rd_data(mem_rd_data)
   );

   // Next state: settings, idle timer and request decode
   always_comb
   begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      // Bad settings are dropped so the held ones stay legal
      if (cfg_load)
      begin
         if (cfg_node_id != 8'h00)
            next_s.node_id = cfg_node_id;
         if (cfg_baud_sel <= `MBS_BAUD_SEL_MAX)
            next_s.baud_sel = cfg_baud_sel;
         if (cfg_timeout_sel <= `MBS_TIMEOUT_MAX)
            next_s.timeout_sel = cfg_timeout_sel;
         next_s.static_ip = cfg_static_ip;
         next_s.static_gw = cfg_static_gw;
         next_s.subnet_mask = cfg_subnet_mask;
         next_s.tcp_port = cfg_tcp_port;
         next_s.dhcp_en = cfg_dhcp_enable;
      end
      // Idle timer: one-second prescaler, then a seconds count
      if (s.timeout_sel == `MBS_TIMEOUT_NONE)
      begin
         next_s.presc = '0;
         next_s.secs = '0;
         next_s.rx_timeout = 1'b0;
      end
      else if (take && for_us)
      begin
         next_s.presc = '0;
         next_s.secs = '0;
         next_s.rx_timeout = 1'b0;
      end
      else if (!s.rx_timeout)
      begin
         if (s.presc == 32'(CYCLES_PER_SEC - 1))
         begin
            next_s.presc = '0;
            next_s.secs = s.secs + 5'h01;
            if (s.secs + 5'h01 >= s.timeout_sel)
               next_s.rx_timeout = 1'b1;
         end
         else
            next_s.presc = s.presc + 32'h00000001;
      end
      // Pending holding read: data is in the store's output register
      if (s.state == mbs_pkg::MBS_HOLD_WAIT)
      begin
         next_s.state = mbs_pkg::MBS_IDLE;
         next_s.rsp_valid = 1'b1;
         next_s.rsp_exc = 1'b0;
         next_s.rsp_data = mem_rd_data;
      end
      // Requests for another unit are taken and dropped silently
      if (take && for_us)
      begin
         next_s.rsp_valid = 1'b1;
         next_s.rsp_func = req_function;
         next_s.rsp_exc = 1'b1;
         next_s.rsp_data = `MBS_EXC_ADDRESS;
         case (req_function)
            `MBS_FN_READ_COILS:
               if (req_address == `MBS_COIL_OPEN_CLOSE)
               begin
                  next_s.rsp_exc = 1'b0;
                  next_s.rsp_data = {15'h0000, s.open_cmd};
               end
            `MBS_FN_READ_INPUTS:
            begin
               next_s.rsp_exc = 1'b0;
               case (req_address)
                  `MBS_IN_OPEN_LIMIT:
                     next_s.rsp_data = {15'h0000,
                        open_limit_indicator};
                  `MBS_IN_CLOSE_LIMIT:
                     next_s.rsp_data = {15'h0000, close_limit_indicator};
                  `MBS_IN_ERROR_RELAY:
                     next_s.rsp_data = {15'h0000, error_relay_status};
                  default:
                  begin
                     next_s.rsp_exc = 1'b1;
                     next_s.rsp_data = `MBS_EXC_ADDRESS;
                  end
               endcase
            end
            `MBS_FN_READ_IREGS:
            begin
               next_s.rsp_exc = 1'b0;
               case (req_address)
                  `MBS_IREG_MAC_HI: next_s.rsp_data = mac_address[47:32];
                  `MBS_IREG_MAC_MID: next_s.rsp_data = mac_address[31:16];
                  `MBS_IREG_MAC_LO: next_s.rsp_data = mac_address[15:0];
                  `MBS_IREG_LOT: next_s.rsp_data = lot_number;
                  default:
                  begin
                     next_s.rsp_exc = 1'b1;
                     next_s.rsp_data = `MBS_EXC_ADDRESS;
                  end
               endcase
            end
            `MBS_FN_READ_HOLDING:
               if (mem_rd)
               begin
                  next_s.rsp_valid = 1'b0;
                  next_s.state = mbs_pkg::MBS_HOLD_WAIT;
               end
            `MBS_FN_WRITE_COIL:
               if (req_address == `MBS_COIL_OPEN_CLOSE)
               begin
                  next_s.rsp_data = req_value;
                  next_s.rsp_exc = 1'b0;
                  if (req_value == `MBS_COIL_ON)
                     next_s.open_cmd = 1'b1;
                  else if (req_value == `MBS_COIL_OFF)
                     next_s.open_cmd = 1'b0;
                  else
                  begin
                     next_s.rsp_exc = 1'b1;
                     next_s.rsp_data = `MBS_EXC_VALUE;
                  end
               end
            `MBS_FN_WRITE_HOLDING:
               if (mem_wr)
               begin
                  next_s.rsp_exc = 1'b0;
                  next_s.rsp_data = req_value;
               end
            // Input tables have no write function, so they stay read only
            default:
               next_s.rsp_data = `MBS_EXC_FUNCTION;
         endcase
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s <= '0;
         s.state <= mbs_pkg::MBS_IDLE;
         s.node_id <= `MBS_RST_NODE_ID;
         s.baud_sel <= `MBS_RST_BAUD_SEL;
         s.tcp_port <= `MBS_RST_TCP_PORT;
      end
      else if (clk_en)
         s <= next_s;
   end

   // Outputs; a lease is only used while it is valid
   assign rsp_valid = s.rsp_valid;
   assign rsp_exception = s.rsp_exc;
   assign rsp_function = s.rsp_func;
   assign rsp_data = s.rsp_data;
   assign open_command = s.open_cmd;
   assign rx_timeout = s.rx_timeout;
   assign bit_period_cycles = baud_div(s.baud_sel);
   assign active_ip_address = (s.dhcp_en && dhcp_lease_valid)
      ? dhcp_lease_ip : s.static_ip;
   assign gateway_address = s.static_gw;
   assign subnet_mask = s.subnet_mask;
   assign tcp_listen_port = s.tcp_port;
   assign dhcp_request = s.dhcp_en;

   a_coil_open: assert property (@(posedge clk) disable iff (!reset_n)
      take && for_us && req_function == `MBS_FN_WRITE_COIL
      && req_address == 16'h0000 && req_value == `MBS_COIL_ON
      |=> open_command && rsp_valid && !rsp_exception)
      else $error("coil write of one did not command open");

   a_coil_close: assert property (@(posedge clk) disable iff (!reset_n)
      take && for_us && req_function == `MBS_FN_WRITE_COIL
      && req_address == 16'h0000 && req_value == `MBS_COIL_OFF
      |=> !open_command)
      else $error("coil write of zero did not command close");

   a_foreign_unit: assert property (@(posedge clk) disable iff (!reset_n)
      take && !for_us |=> !rsp_valid)
      else $error("request for another unit was answered");

   a_unmapped_exc: assert property (@(posedge clk) disable iff (!reset_n)
      take && for_us && req_function == `MBS_FN_READ_COILS
      && req_address != 16'h0000
      |=> rsp_valid && rsp_exception && rsp_data == `MBS_EXC_ADDRESS)
      else $error("unmapped coil read gave no exception");

   a_open_status: assert property (@(posedge clk) disable iff (!reset_n)
      take && for_us && req_function == `MBS_FN_READ_INPUTS
      && req_address == 16'h0000
      |=> rsp_valid && rsp_data[0] == $past(open_limit_indicator))
      else $error("input coil zero does not follow open indicator");

   a_lot_read: assert property (@(posedge clk) disable iff (!reset_n)
      take && for_us && req_function == `MBS_FN_READ_IREGS
      && req_address == 16'h0003
      |=> !rsp_exception && rsp_data == $past(lot_number))
      else $error("lot number read failed");

   a_timeout_none: assert property (@(posedge clk) disable iff (!reset_n)
      s.timeout_sel == `MBS_TIMEOUT_NONE |=> !rx_timeout)
      else $error("timeout tripped while disabled");

   a_static_addr: assert property (@(posedge clk) disable iff (!reset_n)
      !s.dhcp_en |-> active_ip_address == s.static_ip)
      else $error("static address not used with auto address off");

   a_hold_read: assert property (@(posedge clk) disable iff (!reset_n)
      mem_rd |=> !rsp_valid ##1 (rsp_valid && !rsp_exception) [*1])
      else $error("holding read answer not two cycles later");

endmodule
